// ### core/spp_params.svh
// Offsets, field positions, reset values and timing counts for the serial port
`ifndef SPP_PARAMS_SVH
`define SPP_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SPP_OFS_CTRL 8'h00
`define SPP_OFS_DIV 8'h04
`define SPP_OFS_STAT 8'h08
`define SPP_OFS_TXBUF 8'h0c
`define SPP_OFS_RXBUF 8'h10
`define SPP_OFS_IE 8'h14
`define SPP_OFS_IFG 8'h18
`define SPP_OFS_IFG_EN 8'h1c

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define SPP_CTL_HOLD 0
`define SPP_CTL_MST 1
`define SPP_CTL_MSB 2
`define SPP_CTL_CPH 3
`define SPP_CTL_CPL 4
`define SPP_CTL_MODE_LO 5
`define SPP_CTL_MODE_HI 6
`define SPP_CTL_STEM 7
`define SPP_CTL_SEVEN 8

// ----------------------------------------
// Pin modes, flag bits, status bits
// ----------------------------------------
`define SPP_MODE_3PIN 2'h0
`define SPP_MODE_4PIN_HI 2'h1
`define SPP_MODE_4PIN_LO 2'h2
`define SPP_IFG_RX 0
`define SPP_IFG_TX 1
`define SPP_STAT_BUSY 0
`define SPP_STAT_TXFULL 1
`define SPP_STAT_OVR 2

// ----------------------------------------
// Reset values, widths and last edge counts
// ----------------------------------------
`define SPP_DIV_W 16
`define SPP_DIV_RST 16'h0004
`define SPP_LAST_EDGE8 4'hf
`define SPP_LAST_EDGE7 4'hd

`endif

// ### core/spp_pkg.sv
// Types shared by the serial port modules
package spp_pkg;

    typedef enum logic {
        SPP_IDLE,
        SPP_XFER
    } spp_phase_t;

    typedef struct packed {
        logic [15:0] cnt;
    } spp_baud_t;

    typedef struct packed {
        logic soft_reset_hold;
        logic master_select_bit;
        logic bit_order_bit;
        logic clock_phase_bit;
        logic clock_polarity_bit;
        logic [1:0] pin_mode_field;
        logic select_line_function;
        logic short_char_bit;
        logic [15:0] div;
        logic [1:0] event_enable_reg;
        logic [1:0] event_flag_reg;
        logic [7:0] tx_data;
        logic tx_full;
        logic [7:0] rx_data;
        logic overrun;
        spp_phase_t phase;
        logic [7:0] sh;
        logic [3:0] ecnt;
        logic sclk;
        logic dout;
        logic sclk_prev;
        logic [31:0] prdata;
    } spp_state_t;

endpackage

// ### core/spp_baud.sv
// Serial clock half-period tick generator
`timescale 1ns/100ps
module spp_baud #(
    parameter int DIV_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [DIV_W-1:0] div,
    output logic tick
);

    spp_pkg::spp_baud_t s_ff;
    spp_pkg::spp_baud_t nxt_s;

    // ----------------------------------------
    // Half period is div+1 source cycles
    // ----------------------------------------
    always_comb begin
        nxt_s = s_ff;
        tick = 1'b0;
        if (!run) begin
            nxt_s.cnt = 16'h0000;
        end else if (s_ff.cnt == 16'(div)) begin
            nxt_s.cnt = 16'h0000;
            tick = 1'b1;
        end else begin
            nxt_s.cnt = s_ff.cnt + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

endmodule // spp_baud

// ### core/spp_shift.sv
// Shift step and outgoing bit selection for either bit order
`timescale 1ns/100ps
module spp_shift (
    input wire logic [7:0] data,
    input wire logic din,
    input wire logic msb_first,
    input wire logic seven,
    output logic head,
    output logic [7:0] shifted
);

    // ----------------------------------------
    // Order and character length
    // ----------------------------------------
    always_comb begin
        if (msb_first) begin
            head = seven ? data[6] : data[7];
            shifted = {data[6:0], din};
            if (seven) begin
                shifted[7] = 1'b0;
            end
        end else begin
            head = data[0];
            shifted = {1'b0, data[7:1]};
            if (seven) begin
                shifted[6] = din;
            end else begin
                shifted[7] = din;
            end
        end
    end

endmodule // spp_shift

// ### core/spp_ctrl.sv
// Byte serial port with APB registers, master and slave modes
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "spp_params.svh"
module spp_ctrl #(
    parameter int DIV_W = `SPP_DIV_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_n,
    input wire logic simo_i,
    output logic simo_o,
    output logic simo_oe_n,
    input wire logic somi_i,
    output logic somi_o,
    output logic somi_oe_n,
    input wire logic slave_enable_line_i,
    output logic slave_enable_line_o,
    output logic slave_enable_line_oe_n
);

    spp_pkg::spp_state_t s_ff;
    spp_pkg::spp_state_t nxt_s;

    logic four_pin;
    logic ste_act;
    logic conflict;
    logic slv_en;
    logic busy;
    logic tick;
    logic run;
    logic din;
    logic head_w;
    logic [7:0] cap_w;
    logic [7:0] w;
    logic edge_ev;
    logic capture;
    logic [3:0] last;
    logic tx_ev;
    logic rx_ev;
    logic [1:0] clr;
    logic [1:0] setf;
    logic wr_acc;
    logic rd_acc;
    logic rd_setup;
    logic mapped;
    logic [31:0] rd_mux;

    // ----------------------------------------
    // Pin mode decode
    // ----------------------------------------
    assign four_pin = s_ff.pin_mode_field != `SPP_MODE_3PIN;
    assign ste_act = (s_ff.pin_mode_field == `SPP_MODE_4PIN_HI) ? slave_enable_line_i
                                                                : ~slave_enable_line_i;
    // Another master owns the bus: stay off the lines
    assign conflict = s_ff.master_select_bit & four_pin & ~s_ff.select_line_function & ste_act;
    assign slv_en = ~four_pin | ste_act;
    assign busy = s_ff.phase == spp_pkg::SPP_XFER;
    assign last = s_ff.short_char_bit ? `SPP_LAST_EDGE7 : `SPP_LAST_EDGE8;
    assign din = s_ff.master_select_bit ? somi_i : simo_i;

    // ----------------------------------------
    // Clock divider and shift step
    // ----------------------------------------
    assign run = s_ff.master_select_bit & busy & ~s_ff.soft_reset_hold;

    spp_baud #(
        .DIV_W(DIV_W)
    ) u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .div(s_ff.div[DIV_W-1:0]),
        .tick(tick)
    );

    // Idle slave presents the waiting byte so phase 1 has data early
    assign w = (s_ff.phase == spp_pkg::SPP_IDLE) ? (s_ff.tx_full ? s_ff.tx_data : 8'h00) : s_ff.sh;

    spp_shift u_shift (
        .data(w),
        .din(din),
        .msb_first(s_ff.bit_order_bit),
        .seven(s_ff.short_char_bit),
        .head(head_w),
        .shifted(cap_w)
    );

    assign edge_ev = s_ff.master_select_bit ? (tick & ~conflict & busy)
                                            : (slv_en & (sclk_i != s_ff.sclk_prev));
    assign capture = s_ff.ecnt[0] != s_ff.clock_phase_bit;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `SPP_OFS_CTRL: begin
                rd_mux[`SPP_CTL_HOLD] = s_ff.soft_reset_hold;
                rd_mux[`SPP_CTL_MST] = s_ff.master_select_bit;
                rd_mux[`SPP_CTL_MSB] = s_ff.bit_order_bit;
                rd_mux[`SPP_CTL_CPH] = s_ff.clock_phase_bit;
                rd_mux[`SPP_CTL_CPL] = s_ff.clock_polarity_bit;
                rd_mux[`SPP_CTL_MODE_HI:`SPP_CTL_MODE_LO] = s_ff.pin_mode_field;
                rd_mux[`SPP_CTL_STEM] = s_ff.select_line_function;
                rd_mux[`SPP_CTL_SEVEN] = s_ff.short_char_bit;
            end
            `SPP_OFS_DIV: begin
                rd_mux[15:0] = s_ff.div;
            end
            `SPP_OFS_STAT: begin
                rd_mux[`SPP_STAT_BUSY] = busy;
                rd_mux[`SPP_STAT_TXFULL] = s_ff.tx_full;
                rd_mux[`SPP_STAT_OVR] = s_ff.overrun;
            end
            `SPP_OFS_TXBUF: begin
                rd_mux[7:0] = s_ff.tx_data;
            end
            `SPP_OFS_RXBUF: begin
                rd_mux[7:0] = s_ff.rx_data;
            end
            `SPP_OFS_IE: begin
                rd_mux[1:0] = s_ff.event_enable_reg;
            end
            `SPP_OFS_IFG: begin
                rd_mux[1:0] = s_ff.event_flag_reg;
            end
            `SPP_OFS_IFG_EN: begin
                rd_mux[1:0] = s_ff.event_flag_reg & s_ff.event_enable_reg;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_s = s_ff;
        tx_ev = 1'b0;
        rx_ev = 1'b0;
        clr = 2'h0;
        nxt_s.sclk_prev = sclk_i;
        if (rd_setup) begin
            // Captured in setup so the access phase needs no wait
            nxt_s.prdata = rd_mux;
        end

        // Serial engine
        if (s_ff.soft_reset_hold) begin
            nxt_s.phase = spp_pkg::SPP_IDLE;
            nxt_s.ecnt = 4'h0;
            nxt_s.sclk = s_ff.clock_polarity_bit;
            nxt_s.dout = 1'b0;
        end else if (s_ff.master_select_bit) begin
            case (s_ff.phase)
                spp_pkg::SPP_IDLE: begin
                    nxt_s.sclk = s_ff.clock_polarity_bit;
                    if (s_ff.tx_full && !conflict) begin
                        nxt_s.sh = w;
                        nxt_s.tx_full = 1'b0;
                        tx_ev = 1'b1;
                        nxt_s.ecnt = 4'h0;
                        nxt_s.phase = spp_pkg::SPP_XFER;
                        if (s_ff.clock_phase_bit) begin
                            nxt_s.dout = head_w;
                        end
                    end
                end
                spp_pkg::SPP_XFER: begin
                    if (edge_ev) begin
                        nxt_s.sclk = ~s_ff.sclk;
                    end
                end
                default: begin
                    nxt_s.phase = spp_pkg::SPP_IDLE;
                end
            endcase
        end else begin
            if (!slv_en) begin
                // Deselected mid-byte: drop the partial byte
                nxt_s.phase = spp_pkg::SPP_IDLE;
                nxt_s.ecnt = 4'h0;
            end else if (!edge_ev && s_ff.phase == spp_pkg::SPP_IDLE) begin
                nxt_s.dout = head_w;
            end
            if (edge_ev && s_ff.phase == spp_pkg::SPP_IDLE && s_ff.tx_full) begin
                nxt_s.tx_full = 1'b0;
                tx_ev = 1'b1;
            end
        end

        // Shared bit step on each serial clock edge
        if (!s_ff.soft_reset_hold && edge_ev) begin
            if (capture) begin
                nxt_s.sh = cap_w;
            end else begin
                nxt_s.sh = w;
                nxt_s.dout = head_w;
            end
            if (s_ff.ecnt == last) begin
                nxt_s.rx_data = capture ? cap_w : w;
                rx_ev = 1'b1;
                if (s_ff.event_flag_reg[`SPP_IFG_RX]) begin
                    nxt_s.overrun = 1'b1;
                end
                nxt_s.phase = spp_pkg::SPP_IDLE;
                nxt_s.ecnt = 4'h0;
            end else begin
                nxt_s.phase = spp_pkg::SPP_XFER;
                nxt_s.ecnt = s_ff.ecnt + 4'h1;
            end
        end

        // Register writes land at the access edge
        if (wr_acc) begin
            case (paddr)
                `SPP_OFS_CTRL: begin
                    nxt_s.soft_reset_hold = pwdata[`SPP_CTL_HOLD];
                    nxt_s.master_select_bit = pwdata[`SPP_CTL_MST];
                    nxt_s.bit_order_bit = pwdata[`SPP_CTL_MSB];
                    nxt_s.clock_phase_bit = pwdata[`SPP_CTL_CPH];
                    nxt_s.clock_polarity_bit = pwdata[`SPP_CTL_CPL];
                    nxt_s.pin_mode_field = pwdata[`SPP_CTL_MODE_HI:`SPP_CTL_MODE_LO];
                    nxt_s.select_line_function = pwdata[`SPP_CTL_STEM];
                    nxt_s.short_char_bit = pwdata[`SPP_CTL_SEVEN];
                    // Release with an empty buffer asks for the first byte
                    if (s_ff.soft_reset_hold && !pwdata[`SPP_CTL_HOLD] && !s_ff.tx_full) begin
                        tx_ev = 1'b1;
                    end
                end
                `SPP_OFS_DIV: begin
                    nxt_s.div = pwdata[15:0];
                end
                `SPP_OFS_TXBUF: begin
                    nxt_s.tx_data = pwdata[7:0];
                    nxt_s.tx_full = 1'b1;
                    clr[`SPP_IFG_TX] = 1'b1;
                end
                `SPP_OFS_IE: begin
                    nxt_s.event_enable_reg = pwdata[1:0];
                end
                `SPP_OFS_IFG: begin
                    clr = pwdata[1:0];
                end
                default: begin
                end
            endcase
        end
        if (rd_acc && paddr == `SPP_OFS_RXBUF) begin
            clr[`SPP_IFG_RX] = 1'b1;
            nxt_s.overrun = 1'b0;
        end

        // Set beats a clear landing in the same cycle
        setf = {tx_ev, rx_ev};
        nxt_s.event_flag_reg = (s_ff.event_flag_reg & ~clr) | setf;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
            s_ff.soft_reset_hold <= 1'b1;
            s_ff.div <= `SPP_DIV_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = s_ff.prdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign irq = |(s_ff.event_flag_reg & s_ff.event_enable_reg);

    assign sclk_o = s_ff.sclk;
    assign sclk_oe_n = ~(s_ff.master_select_bit & ~conflict);
    assign simo_o = s_ff.dout;
    assign simo_oe_n = ~(s_ff.master_select_bit & ~conflict);
    assign somi_o = s_ff.dout;
    // Deselected slave releases its data line
    assign somi_oe_n = ~(~s_ff.master_select_bit & slv_en & ~s_ff.soft_reset_hold);
    assign slave_enable_line_o = (s_ff.pin_mode_field == `SPP_MODE_4PIN_HI) ? busy : ~busy;
    assign slave_enable_line_oe_n = ~(s_ff.master_select_bit & four_pin & s_ff.select_line_function);

endmodule // spp_ctrl

// ### bench/spp_peer.sv
// Serial slave model on the far side of the port
`timescale 1ns/100ps
module spp_peer (
    input wire logic pclk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic cpha,
    input wire logic msb,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic prev_ff;
    logic [3:0] edge_ff;
    logic [2:0] cap_ff;
    logic [2:0] idx_ff;
    assign miso = tx_byte[msb ? 3'h7 - idx_ff : idx_ff];
    // Edges seen a cycle late; safe since each bit stands a half period
    // Synchronous reset lets the idle clock level be learnt while held
    always_ff @(posedge pclk) begin
        if (!rst_n) begin
            prev_ff <= sclk;
            edge_ff <= 4'h0;
            cap_ff <= 3'h0;
            idx_ff <= 3'h0;
        end else begin
            prev_ff <= sclk;
            if (sclk != prev_ff) begin
                edge_ff <= edge_ff + 4'h1;
                if (edge_ff[0] ^ cpha) begin
                    cap_ff <= cap_ff + 3'h1;
                    rx_byte <= msb ? {rx_byte[6:0], mosi} : {mosi, rx_byte[7:1]};
                end else begin
                    idx_ff <= cap_ff;
                end
            end
        end
    end
endmodule // spp_peer

// ### bench/spp_ctrl_properties.sv
// Concurrent checks on the serial port pins and register bus
`timescale 1ns/100ps
`include "spp_params.svh"
module spp_ctrl_properties #(
    parameter int DIV_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic sclk_o,
    input wire logic sclk_oe_n,
    input wire logic slave_enable_line_i,
    input wire logic slave_enable_line_o,
    input wire logic slave_enable_line_oe_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----
    // Register mirror
    // ----
    logic hold_ff, mst_ff, cpl_ff, stem_ff;
    logic [1:0] mode_ff, ie_ff;
    logic [DIV_W-1:0] div_ff;
    logic [16:0] gap_ff;
    wire logic wr_acc = psel && penable && pwrite && pready;
    wire logic conflict = mst_ff && !hold_ff && mode_ff != 2'h0 && !stem_ff &&
        (slave_enable_line_i == (mode_ff == 2'h1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_ff <= 1'b1;
            {mst_ff, cpl_ff, stem_ff, mode_ff, ie_ff} <= 7'h00;
            div_ff <= `SPP_DIV_RST;
            gap_ff <= 17'h0;
        end else begin
            gap_ff <= $changed(sclk_o) ? 17'h1 : gap_ff + 17'h1;
            if (wr_acc && paddr == `SPP_OFS_CTRL) begin
                {stem_ff, mode_ff, cpl_ff} <= pwdata[7:4];
                {mst_ff, hold_ff} <= pwdata[1:0];
            end
            if (wr_acc && paddr == `SPP_OFS_DIV) div_ff <= pwdata[DIV_W-1:0];
            if (wr_acc && paddr == `SPP_OFS_IE) ie_ff <= pwdata[1:0];
        end
    end
    // ----
    // Assertions
    // ----
    a_apb_slverr: assert property (psel && penable && paddr[1:0] == 2'h0 |->
        pslverr == (paddr > `SPP_OFS_IFG_EN)) else $error("slave error wrong");
    a_irq_masked: assert property (ie_ff == 2'h0 && $past(ie_ff) == 2'h0 |-> !irq)
        else $error("irq with sources disabled");
    a_hold_quiet: assert property ((hold_ff && $stable(cpl_ff)) [*3] ##0 !sclk_oe_n |->
        $stable(sclk_o)) else $error("clock moved while held");
    a_tx_start: assert property (wr_acc && paddr == `SPP_OFS_TXBUF && !hold_ff && mst_ff &&
        !conflict && div_ff <= 4 |-> ##[1:200] $changed(sclk_o)) else $error("no shifting");
    a_sclk_rate: assert property (mst_ff && !hold_ff && $changed(sclk_o) |->
        32'(gap_ff) >= 32'(div_ff) + 32'h1) else $error("clock half period short");
    a_ste_3pin: assert property (mode_ff == 2'h0 && $past(mode_ff) == 2'h0 |->
        slave_enable_line_oe_n) else $error("enable driven in three-pin");
    a_ste_output: assert property (mst_ff && stem_ff && mode_ff != 2'h0 && !hold_ff &&
        sclk_o != cpl_ff |-> !slave_enable_line_oe_n && slave_enable_line_o == (mode_ff == 2'h1))
        else $error("enable output wrong");
    a_ste_conflict: assert property (conflict && $past(conflict) |-> sclk_oe_n)
        else $error("clock driven during conflict");
    c_xfer: cover property (wr_acc && paddr == `SPP_OFS_TXBUF && !hold_ff);
    c_irq: cover property ($rose(irq));
    c_conflict: cover property (conflict);
endmodule // spp_ctrl_properties

// ### bench/spp_ctrl_tb.sv
// Self-checking bench for the serial port controller
`timescale 1ns/100ps
`include "spp_params.svh"
module spp_ctrl_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic ste_i = 1'b0;
    logic peer_rst_n = 1'b0;
    logic cpha = 1'b0;
    logic msb = 1'b0;
    logic [7:0] peer_tx = 8'h00;
    logic [7:0] peer_rx;
    logic [31:0] prdata, e, m;
    logic pready, pslverr, irq, sclk_o, sclk_oe_n, simo_o, simo_oe_n, somi_o, somi_oe_n;
    logic ste_o, ste_oe_n, miso;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int err_total = 0;
    int num_checks = 0;
    int seed = 32'h6a5cb598;
    wire logic somi_w = somi_oe_n ? miso : somi_o;

    spp_ctrl #(.DIV_W(16)) spp_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .sclk_i(sclk_o), .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n),
        .simo_i(simo_o), .simo_o(simo_o), .simo_oe_n(simo_oe_n), .somi_i(somi_w), .somi_o(somi_o),
        .somi_oe_n(somi_oe_n), .slave_enable_line_i(ste_i), .slave_enable_line_o(ste_o),
        .slave_enable_line_oe_n(ste_oe_n));
    spp_peer spp_peer_i (.pclk(pclk), .rst_n(peer_rst_n), .sclk(sclk_o), .mosi(simo_o), .cpha(cpha),
        .msb(msb), .tx_byte(peer_tx), .miso(miso), .rx_byte(peer_rx));

    initial forever #50 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
        exp_q.push_back(x);
        msk_q.push_back(k);
        apb(1'b0, a, 32'h0);
    endtask

    // Read results compared in bus order
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            m = msk_q.pop_front();
            e = exp_q.pop_front();
            chk(prdata & m, e & m);
        end
    end

    task automatic wait_irq;
        for (int i = 0; i < 500 && irq !== 1'b1; i++) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
    endtask

    task automatic xfer(input logic [5:0] c, input logic early);
        logic [7:0] t;
        logic [7:0] p;
        t = 8'($random(seed));
        p = 8'($random(seed));
        apb(1'b1, `SPP_OFS_CTRL, {24'h0, c, 2'h3});
        msb <= c[0];
        cpha <= c[1];
        peer_tx <= p;
        peer_rst_n <= 1'b0;
        // Two cycles so the model sees the new idle level first
        repeat (2) @(posedge pclk);
        peer_rst_n <= 1'b1;
        apb(1'b1, `SPP_OFS_IE, 32'h1);
        if (early) begin
            apb(1'b1, `SPP_OFS_TXBUF, {24'h0, t});
            repeat (100) @(posedge pclk);
            rd(`SPP_OFS_STAT, 32'h0, 32'h1);
        end
        apb(1'b1, `SPP_OFS_CTRL, {24'h0, c, 2'h2});
        if (!early) apb(1'b1, `SPP_OFS_TXBUF, {24'h0, t});
        rd(`SPP_OFS_STAT, 32'h1, 32'h1);
        wait_irq();
        rd(`SPP_OFS_STAT, 32'h0, 32'h1);
        rd(`SPP_OFS_RXBUF, {24'h0, p}, 32'hffffffff);
        chk({24'h0, peer_rx}, {24'h0, t});
        chk({31'h0, sclk_o}, {31'h0, c[2]});
        chk({31'h0, simo_oe_n}, 32'h0);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SPP_OFS_CTRL, 32'h1, 32'hffffffff);
        rd(`SPP_OFS_DIV, {16'h0, `SPP_DIV_RST}, 32'hffffffff);
        rd(`SPP_OFS_IFG, 32'h0, 32'hffffffff);
        rd(8'h20, 32'h0, 32'hffffffff);
        apb(1'b1, `SPP_OFS_DIV, 32'h1);
        $display("test reset values done");
        for (int k = 0; k < 8; k++) xfer(6'(k), 1'b0);
        xfer(6'h00, 1'b1);
        xfer(6'h30, 1'b0);
        xfer(6'h28, 1'b0);
        xfer(6'h20, 1'b0);
        $display("test transfer modes done");
        apb(1'b1, `SPP_OFS_TXBUF, 32'h5a);
        wait_irq();
        apb(1'b1, `SPP_OFS_IE, 32'h0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd(`SPP_OFS_IFG, 32'h3, 32'hffffffff);
        apb(1'b1, `SPP_OFS_IE, 32'h2);
        rd(`SPP_OFS_IFG, 32'h3, 32'hffffffff);
        apb(1'b1, `SPP_OFS_IFG, 32'h1);
        rd(`SPP_OFS_IFG, 32'h2, 32'hffffffff);
        rd(`SPP_OFS_IFG_EN, 32'h2, 32'hffffffff);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `SPP_OFS_IFG, 32'h2);
        rd(`SPP_OFS_IFG, 32'h0, 32'hffffffff);
        chk({31'h0, irq}, 32'h0);
        $display("test interrupts done");
        ste_i <= 1'b1;
        apb(1'b1, `SPP_OFS_CTRL, 32'h23);
        apb(1'b1, `SPP_OFS_CTRL, 32'h22);
        apb(1'b1, `SPP_OFS_TXBUF, 32'h3c);
        rd(`SPP_OFS_STAT, 32'h0, 32'h1);
        chk({30'h0, sclk_oe_n, simo_oe_n}, 32'h3);
        $display("test conflict done");
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge pclk);
        err_total++;
        report_and_stop();
    end
endmodule // spp_ctrl_tb

bind spp_ctrl spp_ctrl_properties #(.DIV_W(DIV_W)) spp_ctrl_properties_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n),
    .slave_enable_line_i(slave_enable_line_i), .slave_enable_line_o(slave_enable_line_o),
    .slave_enable_line_oe_n(slave_enable_line_oe_n));
